// *** core/ssr_core.sv ***
// conversion control and serial readout of the converter
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - select fall wakes device, starts tracking
// - clock level at select fall picks mode
// - internal mode runs on 2MHz oscillator
// - internal: first clock fall samples, converts
// - internal: done stops oscillator, output high
// - external: second clock fall samples, converts
// - frame: three ones, tag, twelve bits
// - tag bit 0/1 by input, pseudo always 1
// - clocks past frame end shift zeros
// - output changes on falls, off when deselected
// - select high shuts everything down
// - select rise aborts running conversion
// - inputs alternate per select cycle from first
module ssr_core (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  // serial link pins
  input  wire logic                         select_shutdown_n,
  input  wire logic                         sclk,
  output var  logic                         dout,
  output var  logic                         doutOe,
  // analog front end
  input  wire logic                         cmpHigh,
  output var  logic                         powerOn,
  output var  logic                         trackEn,
  output var  logic                         oscRun,
  output var  logic                         inputSel,
  output var  logic [ssr_pkg::RES_W-1:0]    dacCode,
  // register port
  input  wire logic [ssr_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [ssr_pkg::DATA_W-1:0]   regWrData,
  input  wire logic                         regWrEn,
  input  wire logic                         regRdEn,
  output var  logic [ssr_pkg::DATA_W-1:0]   regRdData
);
  import ssr_pkg::*;

  localparam logic [RES_W-1:0]  CODE_START = {1'b1, {(RES_W-1){1'b0}}};
  localparam logic [IDX_W-1:0]  IDX_START  = IDX_W'(RES_W - 1);
  localparam logic [IDX_W-1:0]  IDX_ZERO   = 4'h0;
  localparam logic [OSC_CW-1:0] OSC_LAST   = OSC_CW'(OSC_DIV - 1);

  // frame bit for a position, zero before and after the frame
  function automatic logic frameBit(input logic [POS_W-1:0] pos, input logic tag,
                                    input logic [RES_W-1:0] code);
    logic [POS_W-1:0] idx;
    idx = POS_W'(FRAME_LEN) - pos;
    if (pos == POS_ZERO || pos > POS_W'(FRAME_LEN))
      frameBit = 1'b0;
    else if (pos <= POS_W'(LEAD_ONES))
      frameBit = 1'b1;
    else if (pos == POS_W'(TAG_POS))
      frameBit = tag;
    else
      frameBit = code[idx[IDX_W-1:0]];
  endfunction : frameBit

  logic               sclkS1_q, sclkS2_q, sclkPrev_q;
  logic               selS1_q, selS2_q, selPrev_q;
  logic               cmpS1_q, cmpS2_q;
  ssr_state_t         state_q, stateD;
  logic               extMode_q, chanNext_q, pdiff_q;
  logic [POS_W-1:0]   pos_q, posD;
  logic [IDX_W-1:0]   bitIdx_q;
  logic [OSC_CW-1:0]  oscCnt_q;
  logic [RES_W:0]     result_q;
  logic [RES_W-1:0]   codeD;
  logic               doutD;

  // link pins pass two flip-flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkS1_q   <= 1'b0;
      sclkS2_q   <= 1'b0;
      sclkPrev_q <= 1'b0;
      selS1_q    <= 1'b1;
      selS2_q    <= 1'b1;
      selPrev_q  <= 1'b1;
      cmpS1_q    <= 1'b0;
      cmpS2_q    <= 1'b0;
    end else begin
      sclkS1_q   <= sclk;
      sclkS2_q   <= sclkS1_q;
      sclkPrev_q <= sclkS2_q;
      selS1_q    <= select_shutdown_n;
      selS2_q    <= selS1_q;
      selPrev_q  <= selS2_q;
      cmpS1_q    <= cmpHigh;
      cmpS2_q    <= cmpS1_q;
    end
  end

  wire sclkFall = sclkPrev_q & ~sclkS2_q;
  wire selFall  = selPrev_q & ~selS2_q;
  wire selRise  = ~selPrev_q & selS2_q;
  wire selLow   = ~selS2_q;
  wire tagBit   = pdiff_q | inputSel;
  wire oscTick  = oscRun & (oscCnt_q == OSC_LAST);
  wire sampleNow = (state_q == ST_TRACK) & sclkFall & selLow
                   & (~extMode_q | (pos_q == POS_FIRST));
  wire sarStep   = (state_q == ST_CONV) & (extMode_q ? sclkFall : oscTick);
  wire convDone  = sarStep & (bitIdx_q == IDX_ZERO);
  wire posAdv    = sclkFall & selLow & (state_q != ST_OFF)
                   & (extMode_q | (state_q == ST_READ)) & (pos_q != POS_MAX);

  // state sequence
  always_comb begin
    stateD = state_q;
    unique case (state_q)
      ST_OFF:   if (selFall) stateD = ST_TRACK;
      ST_TRACK: if (sampleNow) stateD = ST_CONV;
      ST_CONV:  if (convDone) stateD = ST_READ;
      ST_READ:  stateD = ST_READ;
    endcase
    if (selRise) stateD = ST_OFF;
  end

  // end of internal conversion shows first frame bit
  // position runs past the frame into zeros
  assign posD = selFall ? POS_ZERO
              : (convDone & ~extMode_q) ? POS_FIRST
              : posAdv ? pos_q + POS_FIRST
              : pos_q;

  // successive approximation step, keep or drop the trial bit
  always_comb begin
    codeD = dacCode;
    if (sampleNow) begin
      codeD = CODE_START;
    end else if (sarStep) begin
      codeD[bitIdx_q] = cmpS2_q;
      if (bitIdx_q != IDX_ZERO) codeD[bitIdx_q - 4'h1] = 1'b1;
    end
  end

  // frame content, low until end of conversion in internal mode only
  assign doutD = frameBit(posD, tagBit, codeD);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= ST_OFF;
      pos_q    <= POS_ZERO;
      dacCode  <= '0;
      bitIdx_q <= IDX_ZERO;
      dout     <= 1'b0;
      doutOe   <= 1'b0;
    end else begin
      state_q  <= stateD;
      pos_q    <= posD;
      dacCode  <= codeD;
      bitIdx_q <= sampleNow ? IDX_START : sarStep ? bitIdx_q - 4'h1 : bitIdx_q;
      dout     <= doutD;
      doutOe   <= (stateD != ST_OFF);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerOn    <= 1'b0;
      trackEn    <= 1'b0;
      extMode_q  <= 1'b0;
      inputSel   <= 1'b0;
      chanNext_q <= 1'b0;
    end else begin
      // wake and track on select fall
      powerOn <= (stateD != ST_OFF);
      trackEn <= (stateD == ST_TRACK);
      if (selFall) extMode_q <= ~sclkS2_q;
      if (selFall) begin
        inputSel   <= chanNext_q;
        chanNext_q <= ~chanNext_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscRun   <= 1'b0;
      oscCnt_q <= '0;
    end else begin
      if (selRise || convDone) oscRun <= 1'b0;
      else if (sampleNow && !extMode_q) oscRun <= 1'b1;
      oscCnt_q <= (!oscRun || oscTick) ? '0 : oscCnt_q + 3'h1;
    end
  end

  // register port
  wire regHitCtrl = (regAddr == REG_CTRL);
  wire regHitStat = (regAddr == REG_STATUS);
  wire regHitRes  = (regAddr == REG_RESULT);
  logic [DATA_W-1:0] statWord;
  always_comb begin
    statWord = '0;
    statWord[STAT_POWER_BIT] = powerOn;
    statWord[STAT_EXT_BIT]   = extMode_q;
    statWord[STAT_BUSY_BIT]  = (state_q == ST_CONV);
    statWord[STAT_CHAN_BIT]  = inputSel;
    statWord[STAT_READY_BIT] = (state_q == ST_READ);
  end
  wire [DATA_W-1:0] ctrlWord = {{(DATA_W-1){1'b0}}, pdiff_q};
  wire [DATA_W-1:0] resWord  = {{(DATA_W-RES_W-1){1'b0}}, result_q};
  wire [DATA_W-1:0] rdMux    = regHitCtrl ? ctrlWord : regHitStat ? statWord
                             : regHitRes ? resWord : '0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pdiff_q   <= CTRL_PDIFF_RST;
      result_q  <= '0;
      regRdData <= '0;
    end else begin
      if (regWrEn && regHitCtrl) pdiff_q <= regWrData[CTRL_PDIFF_BIT];
      if (convDone) result_q <= {tagBit, codeD};
      regRdData <= regRdEn ? rdMux : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  wake_track_a: assert property (selFall |=> powerOn && trackEn)
    else $error("no wake on select fall");
  mode_pick_a: assert property (selFall |=> extMode_q == !$past(sclkS2_q))
    else $error("mode not taken from clock level");
  osc_period_a: assert property (oscTick |-> ##1 (!oscTick) [*4])
    else $error("oscillator tick spacing wrong");
  int_sample_a: assert property ((state_q == ST_TRACK && !extMode_q && sclkFall
    && selLow && !selRise) |=> state_q == ST_CONV && !trackEn && oscRun)
    else $error("internal sample missed");
  eoc_high_a: assert property ((convDone && !extMode_q && !selRise)
    |=> dout && !oscRun && state_q == ST_READ)
    else $error("end of conversion not shown");
  ext_sample_a: assert property ((state_q == ST_TRACK && extMode_q && sclkFall
    && pos_q == POS_FIRST && !selRise) |=> state_q == ST_CONV)
    else $error("external sample not on second fall");
  lead_ones_a: assert property ((doutOe && pos_q >= POS_FIRST
    && pos_q <= POS_W'(LEAD_ONES)) |-> dout)
    else $error("leading bit not high");
  tag_bit_a: assert property ((doutOe && pos_q == POS_W'(TAG_POS)) |-> dout == tagBit)
    else $error("tag bit wrong");
  trail_zero_a: assert property ((pos_q > POS_W'(FRAME_LEN)) |-> !dout)
    else $error("trailing bit not zero");
  oe_off_a: assert property (selRise |=> !doutOe && !powerOn && !oscRun)
    else $error("output not released");
  conv_low_a: assert property ((state_q == ST_CONV && !extMode_q) |-> !dout)
    else $error("output high during conversion");
  chan_alt_a: assert property (selFall |=> inputSel == $past(chanNext_q))
    else $error("input not alternated");

  int_done_c: cover property (convDone && !extMode_q);
  ext_done_c: cover property (convDone && extMode_q);
  abort_c:    cover property (selRise && state_q == ST_CONV);
  trail_c:    cover property (doutOe && pos_q > POS_W'(FRAME_LEN));

endmodule : ssr_core

`default_nettype wire

// *** core/ssr_pkg.sv ***
// constants and types for the serial-readout converter control
package ssr_pkg;

  localparam int CLK_HZ  = 10_000_000;
  localparam int OSC_HZ  = 2_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int OSC_CW  = 3;

  localparam int RES_W     = 12;
  localparam int POS_W     = 5;
  localparam int IDX_W     = 4;
  localparam int LEAD_ONES = 3;
  localparam int TAG_POS   = 4;
  localparam int FRAME_LEN = 16;

  localparam logic [POS_W-1:0] POS_MAX   = 5'h1F;
  localparam logic [POS_W-1:0] POS_FIRST = 5'h01;
  localparam logic [POS_W-1:0] POS_ZERO  = 5'h00;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;

  localparam int CTRL_PDIFF_BIT  = 0;
  localparam int STAT_POWER_BIT  = 0;
  localparam int STAT_EXT_BIT    = 1;
  localparam int STAT_BUSY_BIT   = 2;
  localparam int STAT_CHAN_BIT   = 3;
  localparam int STAT_READY_BIT  = 4;
  localparam int RESULT_TAG_BIT  = 12;
  localparam logic CTRL_PDIFF_RST = 1'b0;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV  = 2'b10,
    ST_READ  = 2'b11
  } ssr_state_t;

endpackage : ssr_pkg

// *** tb/ssr_host_model.sv ***
// host serial-clock master for the readout link
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
  // clock
  input  wire logic core_clk,
  // serial link pins
  input  wire logic dout,
  output var  logic select_shutdown_n,
  output var  logic sclk
);
  logic [31:0] rxBits;
  initial begin
    select_shutdown_n = 1'b1;
    sclk              = 1'b0;
    rxBits            = '0;
  end
  task automatic start(input logic intMode);
    @(posedge core_clk);
    sclk <= intMode;
    rxBits = '0;
    @(posedge core_clk);
    select_shutdown_n <= 1'b0;
    repeat (25) @(posedge core_clk);
  endtask : start
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      sclk <= 1'b1;
      repeat (3) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      rxBits = {rxBits[30:0], dout};
    end
  endtask : pulses
  task automatic stop();
    @(posedge core_clk);
    select_shutdown_n <= 1'b1;
    sclk <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask : stop
endmodule : ssr_host_model
`default_nettype wire

// *** tb/test_ssr_core.sv ***
// bench for the converter control and serial readout
`timescale 1ns/1ns
`default_nettype none
module test_ssr_core;
  import ssr_pkg::*;
  logic                   core_clk    = 1'b0;
  logic                   rst_b       = 1'b0;
  logic                   cmpHigh     = 1'b0;
  logic [ADDR_W-1:0]      regAddr     = '0;
  logic [DATA_W-1:0]      regWrData   = '0;
  logic                   regWrEn     = 1'b0;
  logic                   regRdEn     = 1'b0;
  logic [RES_W-1:0]       tgt         = '0;
  logic [DATA_W-1:0]      rd;
  wire logic [DATA_W-1:0] regRdData;
  wire logic [RES_W-1:0]  dacCode;
  wire logic              selN, sclk, dout, doutOe, powerOn, trackEn, oscRun, inputSel;
  int                     miscompares = 0;
  int                     checks_done = 0;
  int                     cnt;

  always #50 core_clk = ~core_clk;
  // comparator keeps trials not above target
  always @(posedge core_clk) cmpHigh <= (dacCode <= tgt);

  ssr_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .select_shutdown_n(selN), .sclk(sclk),
    .dout(dout), .doutOe(doutOe), .cmpHigh(cmpHigh), .powerOn(powerOn), .trackEn(trackEn),
    .oscRun(oscRun), .inputSel(inputSel), .dacCode(dacCode), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
  ssr_host_model host_u (.core_clk(core_clk), .dout(dout), .select_shutdown_n(selN),
    .sclk(sclk));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic regWr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(negedge core_clk);
    rd = regRdData;
  endtask : regRd
  task automatic print_verdict();
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic extFrame(input logic chan);
    host_u.start(1'b0);
    chk(16'(doutOe & powerOn & trackEn), 16'h0001);
    chk(16'(inputSel), 16'(chan));
    host_u.pulses(1);
    chk(16'(trackEn), 16'h0001);
    host_u.pulses(19);
    chk(host_u.rxBits[19:4], {3'h7, chan, tgt});
    chk(16'(host_u.rxBits[3:0]), 16'h0000);
    regRd(REG_RESULT);
    chk(rd[15:0], {3'h0, chan, tgt});
    host_u.stop();
    chk(16'(doutOe | powerOn | oscRun), 16'h0000);
  endtask : extFrame

  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    regRd(REG_CTRL);
    chk(rd[15:0], 16'(CTRL_PDIFF_RST));
    regRd(4'hC);
    chk(rd[15:0], 16'h0000);
    tgt <= 12'hA5C;
    extFrame(1'b0);
    tgt <= 12'h3F1;
    extFrame(1'b1);
    tgt <= 12'h801;
    host_u.start(1'b1);
    host_u.pulses(1);
    chk(host_u.rxBits[15:0], 16'h0000);
    chk(16'(oscRun), 16'h0001);
    cnt = 0;
    while (dout !== 1'b1 && cnt < 200) begin
      @(negedge core_clk);
      cnt++;
    end
    chk(16'(cnt >= 44 && cnt <= 76), 16'h0001);
    repeat (3) @(negedge core_clk);
    chk(16'(oscRun), 16'h0000);
    host_u.pulses(15);
    chk(host_u.rxBits[15:0], {1'b0, 2'h3, 1'b0, tgt});
    host_u.stop();
    host_u.start(1'b0);
    host_u.pulses(4);
    host_u.stop();
    chk(16'(doutOe | trackEn | powerOn), 16'h0000);
    regWr(REG_CTRL, 32'h0000_0001);
    tgt <= 12'h5A3;
    host_u.start(1'b0);
    host_u.pulses(16);
    chk(host_u.rxBits[15:0] >> 8, {8'h00, 4'hF, tgt[11:8]});
    chk(16'(host_u.rxBits[7:0]), 16'(tgt[7:0]));
    host_u.stop();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
endmodule : test_ssr_core
`default_nettype wire
